// ==== rtl/mas_pkg.sv ====
// constants shared by the monitor alert and shutdown control block
package mas_pkg;
  // second control register fields
  localparam int unsigned CB_SHDN_BIT      = 6;
  localparam int unsigned CB_RDCLR_BIT     = 5;
  localparam int unsigned CB_AUTOWAKE_BIT  = 4;
  localparam int unsigned CB_ACCCTL_LSB    = 2;
  localparam int unsigned CB_RSTFLD_LSB    = 0;
  localparam logic [7:0]  CB_RESET_VAL     = 8'h00;
  // accumulation control and reset field codes
  localparam logic [1:0]  ACCCTL_GATED     = 2'h2;
  localparam logic [1:0]  RSTFLD_NONE      = 2'h0;
  localparam logic [1:0]  RSTFLD_ONREAD    = 2'h1;
  localparam logic [1:0]  RSTFLD_HOLD      = 2'h2;
  localparam logic [1:0]  RSTFLD_ALL       = 2'h3;
  // third pin control register fields
  localparam int unsigned GC_ALERT_BIT     = 7;
  localparam int unsigned GC_OUTLOW_BIT    = 6;
  localparam logic [7:0]  GC_RESET_VAL     = 8'h00;
  // second status / fault / alert enable layout
  localparam int unsigned S2_GPIO_LSB      = 4;
  localparam int unsigned S2_WAKE_BIT      = 3;
  localparam int unsigned S2_OVF_LSB       = 0;
  localparam int unsigned AL2_GENERAL_PIN_ONE_BIT    = 6;
  localparam int unsigned AL2_GENERAL_PIN_TWO_BIT    = 5;
  localparam int unsigned AL2_WAKE_BIT     = 3;
  localparam logic [7:0]  FAULT_RESET_VAL  = 8'h00;
  localparam logic [7:0]  SEQ_RESET_VAL    = 8'h00;
  // stuck bus wake time
  localparam int unsigned STUCK_TIME_US    = 33000;
  localparam int unsigned CLK_FREQ_MHZ     = 25;
  localparam int unsigned STUCK_CYC        = STUCK_TIME_US * CLK_FREQ_MHZ + 1;
  localparam int unsigned STUCK_CNT_W      = 20;
endpackage

// ==== rtl/mas_sync.sv ====
// two flip-flop synchroniser for asynchronous pin levels
module mas_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '1;
      q        <= '1;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ==== rtl/mas_stuck_timer.sv ====
// counts cycles while either bus line is low, pulses on expiry
module mas_stuck_timer #(
  parameter int unsigned CYCLES = mas_pkg::STUCK_CYC,
  parameter int unsigned CW     = mas_pkg::STUCK_CNT_W
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda,
  output logic      expire
);
  logic [CW-1:0] cnt_reg;
  logic          done_reg;

  always_ff @(posedge clk) begin
    if (!rst_n || (scl && sda)) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
      expire   <= 1'b0;
    end else if (!done_reg) begin
      cnt_reg  <= cnt_reg + 1'b1;
      // one pulse per low period
      if (cnt_reg == CW'(CYCLES - 1)) begin
        done_reg <= 1'b1;
        expire   <= 1'b1;
      end else begin
        expire   <= 1'b0;
      end
    end else begin
      expire <= 1'b0;
    end
  end
endmodule

// ==== rtl/mas_ctrl.sv ====
// control, alert and fault logic of the power and energy monitor
// Behaviour
// RULE1 - shutdown bit powers analog off; registers and bus stay alive
// RULE2 - clearing shutdown restarts analog; registers keep contents
// RULE3 - auto-wake enabled: bus lines low over 33ms leaves shutdown
// RULE4 - wake event alerts only when its alert enable bit is set
// RULE5 - each general pin input has selectable active polarity
// RULE6 - general pin levels readable in second status bits 6:4
// RULE7 - accumulation field 10 lets pin two gate integration
// RULE8 - pin one and two alerts need enable bits 6 and 5
// RULE9 - general pins drive low or float, never high
// RULE10 - after reset pin three is alert output pulling low on alert
// RULE11 - bit7 forces alert pin only in alert mode, bit6 only as output
// RULE12 - any alert sets bit7 of third pin control register
// RULE13 - reset field 01 clears accumulators after last byte read
// RULE14 - reset field 10 holds accumulators in reset
// RULE15 - reset field 11 resets all registers, field returns to 00
// RULE16 - register reset keeps sequencing; new one on first control write
// RULE17 - conversion beyond stored min or max replaces it
// RULE18 - bus write of a result updates min or max likewise
// RULE19 - thresholds reset to max all ones, min all zeros
// RULE20 - threshold crossing sets live status and latched fault
// RULE21 - enabled latched fault pulls alert pin low in alert mode
// RULE22 - writing zeros clears faults; read clears when bit5 set
// RULE23 - active status sets its fault again the cycle after a clear
module mas_ctrl #(
  parameter int unsigned NCH          = 4,
  parameter int unsigned DW           = 12,
  parameter int unsigned STUCK_CYCLES = mas_pkg::STUCK_CYC
) (
  input  wire logic                     REF_CLK,
  input  wire logic                     RST_N,
  input  wire logic                     SCL_PIN,
  input  wire logic                     SDA_PIN,
  input  wire logic [2:0]               GPIO_PIN,
  input  wire logic                     CTRL1_WR,
  input  wire logic [7:0]               CTRL1_WDATA,
  input  wire logic                     CTRL2_WR,
  input  wire logic [7:0]               CTRL2_WDATA,
  input  wire logic                     GENERAL_PIN_THREE_WR,
  input  wire logic [7:0]               GENERAL_PIN_THREE_WDATA,
  input  wire logic [2:0]               GPIO_DIR_OUT,
  input  wire logic [2:0]               GPIO_POL_HIGH,
  input  wire logic                     GENERAL_PIN_THREE_ALERT_MODE,
  input  wire logic [1:0]               GPIO_DRV_LOW,
  input  wire logic [2*NCH-1:0]         FIRST_ALERT_ENABLE_REG_EN,
  input  wire logic [7:0]               SECOND_ALERT_ENABLE_REG_EN,
  input  wire logic                     FIRST_LATCHED_FAULT_REG_WR,
  input  wire logic                     FIRST_LATCHED_FAULT_REG_RD,
  input  wire logic                     SECOND_LATCHED_FAULT_REG_WR,
  input  wire logic                     SECOND_LATCHED_FAULT_REG_RD,
  input  wire logic [7:0]               FAULT_WDATA,
  input  wire logic                     ACC_LAST_RD,
  input  wire logic [2:0]               ACC_OVF,
  input  wire logic                     SNAPSHOT,
  input  wire logic                     CONV_DONE,
  input  wire logic                     RES_WR,
  input  wire logic [$clog2(NCH)-1:0]   MEAS_CH,
  input  wire logic [DW-1:0]            MEAS_DATA,
  input  wire logic                     THR_WR,
  input  wire logic                     PEAK_WR,
  input  wire logic                     LIM_HI,
  input  wire logic [$clog2(NCH)-1:0]   LIM_CH,
  input  wire logic [DW-1:0]            LIM_DATA,
  input  wire logic [$clog2(NCH)-1:0]   RD_CH,
  output logic      [DW-1:0]            MIN_Q,
  output logic      [DW-1:0]            MAX_Q,
  output logic      [7:0]               CTRL2_Q,
  output logic      [7:0]               THIRD_PIN_CONTROL_REG_Q,
  output logic      [2*NCH-1:0]         FIRST_STATUS_REG,
  output logic      [2*NCH-1:0]         FIRST_LATCHED_FAULT_REG,
  output logic      [7:0]               SECOND_STATUS_REG,
  output logic      [7:0]               SECOND_LATCHED_FAULT_REG,
  output logic                          ANALOG_EN,
  output logic                          ACC_EN,
  output logic                          ACC_CLR,
  output logic                          REG_RST,
  output logic      [7:0]               SEQ_CFG,
  output logic                          SEQ_LOAD,
  output logic      [2:0]               GPIO_O,
  output logic      [2:0]               GPIO_OE
);
  import mas_pkg::*;

  logic [4:0]    pins_s;
  logic          scl_s;
  logic          sda_s;
  logic [2:0]    gpio_s;
  logic          wake_exp;
  logic          soft_rst;
  logic [1:0]    rst_fld;
  logic [2:0]    gpio_act;
  logic          alert_any;
  logic [2*NCH-1:0] stat1_next;
  logic [7:0]    f2_set;
  logic [DW-1:0] val_reg  [NCH];
  logic [DW-1:0] thrlo_reg [NCH];
  logic [DW-1:0] thrhi_reg [NCH];
  logic [DW-1:0] min_reg  [NCH];
  logic [DW-1:0] max_reg  [NCH];
  logic [2:0]    ovf_reg;
  logic          wake_reg;
  logic [1:0]    flush_reg; // pin synchronisers hold reset levels for two edges

  // asynchronous pins pass two flip-flops first
  mas_sync #(.W(5)) u_sync (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .d     ({SCL_PIN, SDA_PIN, GPIO_PIN}),
    .q     (pins_s)
  );
  assign scl_s  = pins_s[4];
  assign sda_s  = pins_s[3];
  assign gpio_s = pins_s[2:0];

  mas_stuck_timer #(.CYCLES(STUCK_CYCLES)) u_stuck (
    .clk    (REF_CLK),
    .rst_n  (RST_N),
    .scl    (scl_s),
    .sda    (sda_s),
    .expire (wake_exp)
  );

  function automatic logic beyond(input logic [DW-1:0] a, input logic [DW-1:0] b,
                                  input logic hi);
    beyond = hi ? (a > b) : (a < b);
  endfunction

  assign rst_fld  = CTRL2_Q[CB_RSTFLD_LSB +: 2];
  assign soft_rst = (rst_fld == RSTFLD_ALL);
  assign gpio_act = ~(gpio_s ^ GPIO_POL_HIGH) & ~GPIO_DIR_OUT & {3{flush_reg[1]}}; // RULE5

  always_ff @(posedge REF_CLK) begin
    flush_reg <= RST_N ? {flush_reg[0], 1'b1} : 2'h0;
  end
  assign alert_any = |(FIRST_LATCHED_FAULT_REG & FIRST_ALERT_ENABLE_REG_EN) | |(SECOND_LATCHED_FAULT_REG & SECOND_ALERT_ENABLE_REG_EN); // RULE4 RULE8

  // second control register
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || soft_rst) begin
      CTRL2_Q <= CB_RESET_VAL; // RULE15
    end else if (CTRL2_WR) begin
      CTRL2_Q <= CTRL2_WDATA; // RULE1 RULE2
    end else if (wake_exp && CTRL2_Q[CB_AUTOWAKE_BIT] && CTRL2_Q[CB_SHDN_BIT]) begin
      CTRL2_Q[CB_SHDN_BIT] <= 1'b0; // RULE3
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_exp && CTRL2_Q[CB_AUTOWAKE_BIT] && CTRL2_Q[CB_SHDN_BIT];
    end
  end

  // analog power and accumulator control
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ANALOG_EN <= 1'b0;
      ACC_EN    <= 1'b0;
      ACC_CLR   <= 1'b0;
      REG_RST   <= 1'b0;
    end else begin
      ANALOG_EN <= !CTRL2_Q[CB_SHDN_BIT]; // RULE1 RULE2
      ACC_EN    <= !CTRL2_Q[CB_SHDN_BIT] && !SNAPSHOT &&
                   ((CTRL2_Q[CB_ACCCTL_LSB +: 2] != ACCCTL_GATED) || gpio_act[1]); // RULE7
      ACC_CLR   <= (rst_fld == RSTFLD_HOLD) || soft_rst || // RULE14
                   ((rst_fld == RSTFLD_ONREAD) && ACC_LAST_RD); // RULE13
      REG_RST   <= soft_rst;
    end
  end

  // sequencing survives register reset
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SEQ_CFG  <= SEQ_RESET_VAL;
      SEQ_LOAD <= 1'b0;
    end else begin
      SEQ_LOAD <= CTRL1_WR; // RULE16
      if (CTRL1_WR) begin
        SEQ_CFG <= CTRL1_WDATA; // RULE16
      end
    end
  end

  // third pin control: alert sets bit7, set wins over write
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || soft_rst) begin
      THIRD_PIN_CONTROL_REG_Q <= GC_RESET_VAL;
    end else begin
      if (GENERAL_PIN_THREE_WR) begin
        THIRD_PIN_CONTROL_REG_Q <= GENERAL_PIN_THREE_WDATA;
      end
      if (alert_any) begin
        THIRD_PIN_CONTROL_REG_Q[GC_ALERT_BIT] <= 1'b1; // RULE12
      end
    end
  end

  // pin drivers: open drain, low only
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      GPIO_O  <= 3'h0;
      GPIO_OE <= 3'h0;
    end else begin
      GPIO_O     <= 3'h0; // RULE9
      GPIO_OE[0] <= GPIO_DIR_OUT[0] && GPIO_DRV_LOW[0];
      GPIO_OE[1] <= GPIO_DIR_OUT[1] && GPIO_DRV_LOW[1];
      if (GENERAL_PIN_THREE_ALERT_MODE) begin
        GPIO_OE[2] <= alert_any || THIRD_PIN_CONTROL_REG_Q[GC_ALERT_BIT]; // RULE10 RULE11 RULE21
      end else begin
        GPIO_OE[2] <= GPIO_DIR_OUT[2] && THIRD_PIN_CONTROL_REG_Q[GC_OUTLOW_BIT]; // RULE11
      end
    end
  end

  // measured values, thresholds and peak hold
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || soft_rst) begin
      for (int i = 0; i < NCH; i++) begin
        val_reg[i]   <= '0;
        thrlo_reg[i] <= '0; // RULE19
        thrhi_reg[i] <= '1; // RULE19
        min_reg[i]   <= '1;
        max_reg[i]   <= '0;
      end
    end else begin
      if (CONV_DONE || RES_WR) begin
        val_reg[MEAS_CH] <= MEAS_DATA;
        if (beyond(MEAS_DATA, min_reg[MEAS_CH], 1'b0)) begin
          min_reg[MEAS_CH] <= MEAS_DATA; // RULE17 RULE18
        end
        if (beyond(MEAS_DATA, max_reg[MEAS_CH], 1'b1)) begin
          max_reg[MEAS_CH] <= MEAS_DATA; // RULE17 RULE18
        end
      end
      if (THR_WR && LIM_HI) begin
        thrhi_reg[LIM_CH] <= LIM_DATA;
      end
      if (THR_WR && !LIM_HI) begin
        thrlo_reg[LIM_CH] <= LIM_DATA;
      end
      if (PEAK_WR && LIM_HI) begin
        max_reg[LIM_CH] <= LIM_DATA;
      end
      if (PEAK_WR && !LIM_HI) begin
        min_reg[LIM_CH] <= LIM_DATA;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      MIN_Q <= '0;
      MAX_Q <= '0;
    end else begin
      MIN_Q <= min_reg[RD_CH];
      MAX_Q <= max_reg[RD_CH];
    end
  end

  // live threshold status, low bit under, high bit over
  always_comb begin
    stat1_next = '0;
    for (int i = 0; i < NCH; i++) begin
      stat1_next[2*i]   = beyond(val_reg[i], thrlo_reg[i], 1'b0); // RULE20
      stat1_next[2*i+1] = beyond(val_reg[i], thrhi_reg[i], 1'b1); // RULE20
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N || soft_rst) begin
      FIRST_STATUS_REG <= '0;
    end else begin
      FIRST_STATUS_REG <= stat1_next;
    end
  end

  // overflow stays set until accumulators clear
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || soft_rst) begin
      ovf_reg <= 3'h0;
    end else if (ACC_CLR) begin
      ovf_reg <= ACC_OVF;
    end else begin
      ovf_reg <= ovf_reg | ACC_OVF;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SECOND_STATUS_REG <= 8'h00;
    end else begin
      SECOND_STATUS_REG <= {1'b0, gpio_s, wake_reg, ovf_reg}; // RULE6
    end
  end

  always_comb begin
    f2_set = {1'b0, SECOND_STATUS_REG[6:0]};
    f2_set[S2_GPIO_LSB +: 3]          = 3'h0;
    f2_set[AL2_GENERAL_PIN_ONE_BIT]             = gpio_act[0];
    f2_set[AL2_GENERAL_PIN_TWO_BIT]             = gpio_act[1];
  end

  // latched faults: status sets win over clears
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || soft_rst) begin
      FIRST_LATCHED_FAULT_REG <= '0;
    end else if (FIRST_LATCHED_FAULT_REG_WR) begin
      FIRST_LATCHED_FAULT_REG <= FAULT_WDATA[2*NCH-1:0] | FIRST_STATUS_REG; // RULE22 RULE23
    end else if (FIRST_LATCHED_FAULT_REG_RD && CTRL2_Q[CB_RDCLR_BIT]) begin
      FIRST_LATCHED_FAULT_REG <= FIRST_STATUS_REG; // RULE22 RULE23
    end else begin
      FIRST_LATCHED_FAULT_REG <= FIRST_LATCHED_FAULT_REG | FIRST_STATUS_REG; // RULE20
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N || soft_rst) begin
      SECOND_LATCHED_FAULT_REG <= FAULT_RESET_VAL;
    end else if (SECOND_LATCHED_FAULT_REG_WR) begin
      SECOND_LATCHED_FAULT_REG <= FAULT_WDATA | f2_set; // RULE22 RULE23
    end else if (SECOND_LATCHED_FAULT_REG_RD && CTRL2_Q[CB_RDCLR_BIT]) begin
      SECOND_LATCHED_FAULT_REG <= f2_set; // RULE22 RULE23
    end else begin
      SECOND_LATCHED_FAULT_REG <= SECOND_LATCHED_FAULT_REG | f2_set;
    end
  end

  a_shdn_power: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE1
    CTRL2_Q[CB_SHDN_BIT] |=> !ANALOG_EN) else $error("analog on in shutdown");
  a_wake_exit: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE3
    wake_exp && CTRL2_Q[CB_AUTOWAKE_BIT] && CTRL2_Q[CB_SHDN_BIT] && !CTRL2_WR && !soft_rst
    |=> !CTRL2_Q[CB_SHDN_BIT] ##1 ANALOG_EN) else $error("auto wake failed");
  a_pin_low_only: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE9
    GPIO_O == 3'h0) else $error("pin driven high");
  a_acc_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE7
    CTRL2_Q[CB_ACCCTL_LSB +: 2] == ACCCTL_GATED && !gpio_act[1] |=> !ACC_EN)
    else $error("integration not gated");
  a_acc_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE14
    rst_fld == RSTFLD_HOLD |=> ACC_CLR) else $error("accumulators not held");
  a_last_read: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE13
    rst_fld == RSTFLD_ONREAD && ACC_LAST_RD |=> ACC_CLR) else $error("no clear on read");
  a_soft_reset: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE15
    CTRL2_WR && CTRL2_WDATA[1:0] == RSTFLD_ALL |=> ##1 REG_RST && CTRL2_Q[1:0] == RSTFLD_NONE)
    else $error("register reset missing");
  a_seq_keep: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE16
    !CTRL1_WR |=> $stable(SEQ_CFG)) else $error("sequencing changed");
  a_alert_pin: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE21
    GENERAL_PIN_THREE_ALERT_MODE && alert_any |=> GPIO_OE[2]) else $error("alert pin not low");
  a_alert_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE12
    alert_any && !soft_rst |=> THIRD_PIN_CONTROL_REG_Q[GC_ALERT_BIT]) else $error("alert flag unset");
  a_fault_again: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE23
    !soft_rst |=> (FIRST_LATCHED_FAULT_REG & $past(FIRST_STATUS_REG)) == $past(FIRST_STATUS_REG)) else $error("fault lost");
  a_read_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE22
    FIRST_LATCHED_FAULT_REG_RD && !FIRST_LATCHED_FAULT_REG_WR && CTRL2_Q[CB_RDCLR_BIT] && !soft_rst
    |=> FIRST_LATCHED_FAULT_REG == $past(FIRST_STATUS_REG)) else $error("read clear failed");

  c_wake: cover property (@(posedge REF_CLK) wake_reg);
  c_soft: cover property (@(posedge REF_CLK) REG_RST);
  c_alert: cover property (@(posedge REF_CLK) GENERAL_PIN_THREE_ALERT_MODE && GPIO_OE[2]);
  c_rdclr: cover property (@(posedge REF_CLK) rst_fld == RSTFLD_ONREAD && ACC_LAST_RD);
endmodule

// ==== tb/mas_host_model.sv ====
// two-wire host model driving the bus lines seen by the monitor
module mas_host_model (
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;

  // pulled-up lines, idle high
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // clock line held low as when the host side loses its supply
  task automatic stall(input int ns_low);
    scl = 1'b0;
    #(ns_low);
    scl = 1'b1;
  endtask
endmodule

// ==== tb/tb_mas_ctrl.sv ====
// self-checking bench for the monitor alert and shutdown control block
module tb_mas_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import mas_pkg::*;

  logic        REF_CLK, RST_N, SCL_PIN, SDA_PIN, CTRL1_WR, CTRL2_WR, GENERAL_PIN_THREE_WR, GENERAL_PIN_THREE_ALERT_MODE;
  logic        FIRST_LATCHED_FAULT_REG_WR, FIRST_LATCHED_FAULT_REG_RD, SECOND_LATCHED_FAULT_REG_WR, SECOND_LATCHED_FAULT_REG_RD, ACC_LAST_RD, SNAPSHOT, CONV_DONE;
  logic        RES_WR, THR_WR, PEAK_WR, LIM_HI, ANALOG_EN, ACC_EN, ACC_CLR, REG_RST, SEQ_LOAD;
  logic [1:0]  GPIO_DRV_LOW, MEAS_CH, LIM_CH, RD_CH;
  logic [2:0]  GPIO_PIN, GPIO_DIR_OUT, GPIO_POL_HIGH, ACC_OVF, GPIO_O, GPIO_OE;
  logic [7:0]  CTRL1_WDATA, CTRL2_WDATA, GENERAL_PIN_THREE_WDATA, FIRST_ALERT_ENABLE_REG_EN, SECOND_ALERT_ENABLE_REG_EN, FAULT_WDATA;
  logic [7:0]  CTRL2_Q, THIRD_PIN_CONTROL_REG_Q, FIRST_STATUS_REG, FIRST_LATCHED_FAULT_REG, SECOND_STATUS_REG, SECOND_LATCHED_FAULT_REG, SEQ_CFG;
  logic [11:0] MEAS_DATA, LIM_DATA, MIN_Q, MAX_Q;
  int          err_total, total_checks;

  mas_ctrl #(.STUCK_CYCLES(20)) dut (.*);
  mas_host_model host (.scl(SCL_PIN), .sda(SDA_PIN));

  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask

  task automatic finish_test;
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic ctrl2(input logic [7:0] d);
    CTRL2_WDATA = d;
    CTRL2_WR = 1'b1;
    cyc(1);
    CTRL2_WR = 1'b0;
    cyc(3);
  endtask

  task automatic gc(input logic [7:0] d);
    GENERAL_PIN_THREE_WDATA = d;
    GENERAL_PIN_THREE_WR = 1'b1;
    cyc(1);
    GENERAL_PIN_THREE_WR = 1'b0;
    cyc(3);
  endtask

  // sel 0 writes the first fault register, 1 the second
  task automatic fault_wr(input bit sel, input logic [7:0] d);
    FAULT_WDATA = d;
    {SECOND_LATCHED_FAULT_REG_WR, FIRST_LATCHED_FAULT_REG_WR} = sel ? 2'b10 : 2'b01;
    cyc(1);
    {SECOND_LATCHED_FAULT_REG_WR, FIRST_LATCHED_FAULT_REG_WR} = 2'b00;
    cyc(3);
  endtask

  task automatic measure(input bit res, input logic [1:0] ch, input logic [11:0] d);
    MEAS_CH = ch;
    MEAS_DATA = d;
    {RES_WR, CONV_DONE} = res ? 2'b10 : 2'b01;
    cyc(1);
    {RES_WR, CONV_DONE} = 2'b00;
    cyc(5);
  endtask

  task automatic thr(input logic hi, input logic [1:0] ch, input logic [11:0] d);
    LIM_HI = hi;
    LIM_CH = ch;
    LIM_DATA = d;
    THR_WR = 1'b1;
    cyc(1);
    THR_WR = 1'b0;
    cyc(2);
  endtask

  task automatic t_reset;
    chk("ctrl2", 8'h00, CTRL2_Q);
    chk("pin3 ctrl", 8'h00, THIRD_PIN_CONTROL_REG_Q);
    chk("faults", 16'h0000, {FIRST_LATCHED_FAULT_REG, SECOND_LATCHED_FAULT_REG});
    chk("alert pin", 1'b0, GPIO_OE[2]);
  endtask

  task automatic t_shutdown;
    CTRL1_WDATA = 8'hA5;
    CTRL1_WR = 1'b1;
    cyc(1);
    chk("seq load", 1'b1, SEQ_LOAD);
    CTRL1_WR = 1'b0;
    ctrl2(8'h40);
    chk("shutdown", 2'b10, {CTRL2_Q[6], ANALOG_EN});
    chk("seq kept", 8'hA5, SEQ_CFG);
    ctrl2(8'h00);
    chk("restart", 9'h1A5, {ANALOG_EN, SEQ_CFG});
  endtask

  task automatic t_wake(input bit en);
    SECOND_ALERT_ENABLE_REG_EN = en ? 8'h08 : 8'h00;
    ctrl2(8'h50);
    host.stall(40 * 40);
    cyc(6);
    chk("wake", 9'h021, {CTRL2_Q, ANALOG_EN});
    chk("wake fault", 1'b1, SECOND_LATCHED_FAULT_REG[3]);
    chk("wake alert", en, GPIO_OE[2]);
    if (en) chk("alert mark", 1'b1, THIRD_PIN_CONTROL_REG_Q[7]);
    SECOND_ALERT_ENABLE_REG_EN = 8'h00;
    ctrl2(8'h20);
    {SECOND_LATCHED_FAULT_REG_RD, FIRST_LATCHED_FAULT_REG_RD} = 2'b11;
    cyc(1);
    {SECOND_LATCHED_FAULT_REG_RD, FIRST_LATCHED_FAULT_REG_RD} = 2'b00;
    cyc(3);
    chk("read clear", 16'h0000, {FIRST_LATCHED_FAULT_REG, SECOND_LATCHED_FAULT_REG});
    ctrl2(8'h00);
    gc(8'h00);
    chk("released", 1'b0, GPIO_OE[2]);
  endtask

  task automatic t_gc;
    gc(8'h80);
    chk("force low", 1'b1, GPIO_OE[2]);
    gc(8'h00);
    chk("release", 1'b0, GPIO_OE[2]);
    GENERAL_PIN_THREE_ALERT_MODE = 1'b0;
    GPIO_DIR_OUT = 3'b100;
    gc(8'h80);
    chk("bit7 ignored", 1'b0, GPIO_OE[2]);
    gc(8'h40);
    chk("out low", 1'b1, GPIO_OE[2]);
    gc(8'h00);
    GENERAL_PIN_THREE_ALERT_MODE = 1'b1;
    GPIO_DIR_OUT = 3'b000;
    cyc(2);
  endtask

  task automatic t_minmax;
    measure(0, 2'd0, 12'h100);
    measure(0, 2'd0, 12'h050);
    measure(0, 2'd0, 12'h200);
    chk("conv peaks", 24'h050200, {MIN_Q, MAX_Q});
    measure(1, 2'd0, 12'h300);
    measure(1, 2'd0, 12'h020);
    chk("bus peaks", 24'h020300, {MIN_Q, MAX_Q});
  endtask

  task automatic t_thresh;
    FIRST_ALERT_ENABLE_REG_EN = 8'h08;
    measure(0, 2'd1, 12'hFFF);
    chk("disabled", 8'h00, FIRST_LATCHED_FAULT_REG);
    thr(1'b1, 2'd1, 12'h010);
    thr(1'b0, 2'd2, 12'h080);
    measure(0, 2'd1, 12'h020);
    measure(0, 2'd2, 12'h040);
    chk("first_status_reg", 8'h18, FIRST_STATUS_REG);
    chk("first_latched_fault_reg", 8'h18, FIRST_LATCHED_FAULT_REG);
    chk("alert", 2'b11, {GPIO_OE[2], THIRD_PIN_CONTROL_REG_Q[7]});
    fault_wr(0, 8'h00);
    chk("reappear", 8'h18, FIRST_LATCHED_FAULT_REG);
    measure(0, 2'd1, 12'h005);
    measure(0, 2'd2, 12'h090);
    fault_wr(0, 8'h00);
    chk("cleared", 16'h0000, {FIRST_STATUS_REG, FIRST_LATCHED_FAULT_REG});
    FIRST_ALERT_ENABLE_REG_EN = 8'h00;
    gc(8'h00);
  endtask

  task automatic t_softreset;
    measure(0, 2'd1, 12'h020);
    CTRL2_WDATA = 8'h03;
    CTRL2_WR = 1'b1;
    cyc(1);
    CTRL2_WR = 1'b0;
    cyc(1);
    chk("reg reset", 1'b1, REG_RST);
    cyc(2);
    chk("field", 8'h00, CTRL2_Q);
    chk("first_latched_fault_reg", 8'h00, FIRST_LATCHED_FAULT_REG);
    chk("seq", 8'hA5, SEQ_CFG);
    chk("peak", 12'h000, MAX_Q);
    measure(0, 2'd1, 12'hFFE);
    chk("thr reset", 8'h00, FIRST_LATCHED_FAULT_REG);
  endtask

  task automatic t_acc;
    int n;
    n = 0;
    ctrl2(8'h02);
    cyc(3);
    chk("held clr", 1'b1, ACC_CLR);
    ctrl2(8'h01);
    chk("clr off", 1'b0, ACC_CLR);
    ACC_LAST_RD = 1'b1;
    repeat (4) begin
      cyc(1);
      ACC_LAST_RD = 1'b0;
      if (ACC_CLR === 1'b1) n++;
    end
    chk("clr pulse", 1, n);
    ctrl2(8'h08);
    cyc(3);
    chk("gate off", 1'b0, ACC_EN);
    GPIO_PIN = 3'b010;
    cyc(5);
    chk("gate on", 1'b1, ACC_EN);
    ACC_OVF = 3'b010;
    cyc(1);
    ACC_OVF = 3'b000;
    cyc(3);
    fault_wr(1, 8'h00);
    chk("ovf sticky", 4'b0101, {SECOND_STATUS_REG[2:0], SECOND_LATCHED_FAULT_REG[1]});
    ctrl2(8'h02);
    ctrl2(8'h00);
    fault_wr(1, 8'h00);
    chk("ovf gone", 3'b000, SECOND_LATCHED_FAULT_REG[2:0]);
  endtask

  task automatic t_gpio;
    GPIO_PIN = 3'b101;
    GPIO_POL_HIGH = 3'b000;
    cyc(5);
    chk("levels", 3'b101, SECOND_STATUS_REG[6:4]);
    fault_wr(1, 8'h00);
    chk("polarity", 2'b01, SECOND_LATCHED_FAULT_REG[6:5]);
    chk("no alert", 1'b0, GPIO_OE[2]);
    SECOND_ALERT_ENABLE_REG_EN = 8'h20;
    cyc(4);
    chk("pin alert", 1'b1, GPIO_OE[2]);
    SECOND_ALERT_ENABLE_REG_EN = 8'h00;
    GPIO_PIN = 3'b111;
    cyc(4);
    fault_wr(1, 8'h00);
    gc(8'h00);
    GPIO_DIR_OUT = 3'b011;
    GPIO_DRV_LOW = 2'b10;
    cyc(3);
    chk("drive", 6'b000010, {GPIO_O, GPIO_OE});
  endtask

  initial begin
    {CTRL1_WR, CTRL2_WR, GENERAL_PIN_THREE_WR, FIRST_LATCHED_FAULT_REG_WR, FIRST_LATCHED_FAULT_REG_RD, SECOND_LATCHED_FAULT_REG_WR, SECOND_LATCHED_FAULT_REG_RD} = '0;
    {ACC_LAST_RD, SNAPSHOT, CONV_DONE, RES_WR, THR_WR, PEAK_WR, LIM_HI} = '0;
    {GPIO_DRV_LOW, MEAS_CH, LIM_CH, RD_CH, GPIO_PIN, GPIO_DIR_OUT, ACC_OVF} = '0;
    {CTRL1_WDATA, CTRL2_WDATA, GENERAL_PIN_THREE_WDATA, FIRST_ALERT_ENABLE_REG_EN, SECOND_ALERT_ENABLE_REG_EN, FAULT_WDATA} = '0;
    {MEAS_DATA, LIM_DATA} = '0;
    GPIO_POL_HIGH = 3'b111;
    GENERAL_PIN_THREE_ALERT_MODE = 1'b1;
    err_total = 0;
    total_checks = 0;
    RST_N = 1'b0;
    cyc(2);
    RST_N = 1'b1;
    cyc(3);
    t_reset();
    t_shutdown();
    t_wake(1'b0);
    t_wake(1'b1);
    t_gc();
    t_minmax();
    t_thresh();
    t_softreset();
    t_acc();
    t_gpio();
    finish_test();
  end

  // limit well above the expected run length
  initial begin
    #(40 * 4000);
    err_total++;
    finish_test();
  end
endmodule
